// >>> design/acs_pkg.sv
// Package with register map, field layout, timing counts and types of the conversion sequencer.
package acs_pkg;
   // Register byte addresses on the APB.
   localparam logic [7:0] ADDR_SELECT   = 8'h00;
   localparam logic [7:0] ADDR_CTRL_A   = 8'h04;
   localparam logic [7:0] ADDR_CTRL_B   = 8'h08;
   localparam logic [7:0] ADDR_RES_LOW  = 8'h0C;
   localparam logic [7:0] ADDR_RES_HIGH = 8'h10;
   // Field positions in input_select_reg.
   localparam int SEL_CHAN_LSB = 0;
   localparam int SEL_LEFT_BIT = 5;
   localparam int SEL_REF_LSB  = 6;
   // Field positions in converter_ctrl_a and converter_ctrl_b.
   localparam int CA_PS_LSB    = 0;
   localparam int CA_FLAG_BIT  = 4;
   localparam int CA_AUTO_BIT  = 5;
   localparam int CA_START_BIT = 6;
   localparam int CA_EN_BIT    = 7;
   localparam int CB_TS_LSB    = 0;
   // Reset values.
   localparam logic [2:0] PS_RST = 3'h0;
   localparam logic [2:0] TS_RST = 3'h0;
   // Trigger source code that selects the completion flag (free running).
   localparam logic [2:0] FREE_RUN_SRC = 3'h0;
   // Conversion lengths and sample points in converter clock half cycles.
   localparam logic [5:0] HALF_NORM  = 6'h1A;
   localparam logic [5:0] HALF_FIRST = 6'h32;
   localparam logic [5:0] HALF_AUTO  = 6'h1B;
   localparam logic [5:0] SH_NORM    = 6'h03;
   localparam logic [5:0] SH_FIRST   = 6'h1B;
   localparam logic [5:0] SH_AUTO    = 6'h04;
   localparam logic [5:0] LAST_CYCLE = 6'h02;
   // Sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_CONV = 2'b10
   } acs_state_type;
   // Channel and reference selection as handed to the analog core.
   typedef struct packed {
      logic [1:0] ref_sel;
      logic [3:0] chan;
   } acs_sel_type;
endpackage

// >>> design/acs_sequencer.sv
// Conversion sequencer of a 10-bit converter with APB registers and prescaler.
//
// How it works
// - Ten-bit result, right or left justified.
// - Selections ignored until converter enabled.
// - Low byte read locks results until high.
// - Completion flag set even when result discarded.
// - Start bit begins conversion, cleared at end.
// - Channel change waits for final converter cycle.
// - Trigger edge resets prescaler, starts conversion.
// - Held trigger or edges mid-conversion ignored.
// - Flags set regardless; software clears trigger flag.
// - Completion flag source means free running.
// - Start bit works under auto-trigger; reads busy.
// - Prescaler divides clock, reset while disabled.
// - Written start begins on next clock rise.
// - Thirteen cycles, twenty-five for first conversion.
// - Sample at 1.5 or 13.5 cycles.
// - Completion writes result, flag, clears start.
// - Auto-trigger: sample two cycles, 13.5 total.
// - Free running restarts immediately, start stays set.
// - Selections track temp register until start.
// - Tracking resumes in final converter cycle.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
module acs_sequencer (
   // Clock and reset.
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave.
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // On-chip trigger sources, same clock.
   input  wire logic [7:0]        trig_src,
   // Analog sampling core.
   input  wire logic [9:0]        core_result,
   output logic                   adc_clk,
   output logic                   sample_hold,
   output logic                   conv_active,
   output acs_pkg::acs_sel_type   act_sel
);
   acs_pkg::acs_state_type state_q, state_d;
   acs_pkg::acs_sel_type   tmp_sel_q, tmp_sel_d, act_sel_q, act_sel_d;
   logic       left_q, left_d, en_q, en_d, auto_q, auto_d, flag_q, flag_d;
   logic       lock_q, lock_d, first_q, first_d, trig_prev_q, sample_q, sample_d;
   logic       adc_clk_q, adc_clk_d, active_q, active_d;
   logic       pready_q, pready_d, pslverr_q, pslverr_d;
   logic [2:0] ps_q, ps_d, ts_q, ts_d, trig_dly_q, trig_dly_d;
   logic [5:0] hcnt_q, hcnt_d, total_q, total_d, sh_q, sh_d;
   logic [6:0] pcnt_q, pcnt_d;
   logic [9:0] res_q, res_d;
   logic [31:0] prdata_q, prdata_d;
   logic       wr, rd, rise_tick, fall_tick, trig_go, trig_edge, done, track;
   logic [7:0] div;

   // Division ratio of the prescaler; codes 0 and 1 both divide by two.
   function automatic logic [7:0] div_of(input logic [2:0] ps);
      div_of = (ps == 3'h0) ? 8'h02 : 8'h01 << ps;
   endfunction

   // Bus strobes: a transfer takes effect only at the edge that completes it.
   assign wr = psel & penable & pready_q & pwrite;
   assign rd = psel & penable & pready_q & ~pwrite;

   // Trigger edge detect on the selected source; only edges outside a conversion count.
   assign trig_edge = trig_src[ts_q] & ~trig_prev_q;
   assign trig_go   = trig_dly_q[2] & en_q & auto_q & (state_q != acs_pkg::ST_CONV);

   // Prescaler ticks; the rise tick is the converter clock's rising edge.
   assign div       = div_of(ps_q);
   assign rise_tick = en_q & ~trig_go & (pcnt_q == div[6:0] - 7'h01);
   assign fall_tick = en_q & ~trig_go & (pcnt_q == div[7:1] - 7'h01);

   // Prescaler next state.
   always_comb begin
      pcnt_d    = pcnt_q + 7'h01;
      adc_clk_d = adc_clk_q;
      if (!en_q || trig_go) begin
         // A trigger restarts the count so its delay to sampling is fixed.
         pcnt_d    = 7'h00;
         adc_clk_d = en_q;
      end else if (rise_tick) begin
         pcnt_d    = 7'h00;
         adc_clk_d = 1'b1;
      end else if (fall_tick) begin
         adc_clk_d = 1'b0;
      end
   end

   // Selections follow the temporary register except inside the locked part of a conversion.
   assign track = (state_q != acs_pkg::ST_CONV) || (hcnt_q + acs_pkg::LAST_CYCLE >= total_q);

   // Sequencer, flag and result next state.
   always_comb begin
      state_d    = state_q;
      hcnt_d     = hcnt_q;
      total_d    = total_q;
      sh_d       = sh_q;
      first_d    = first_q;
      flag_d     = flag_q;
      lock_d     = lock_q;
      res_d      = res_q;
      sample_d   = 1'b0;
      done       = 1'b0;
      act_sel_d  = act_sel_q;
      tmp_sel_d  = tmp_sel_q;
      left_d     = left_q;
      en_d       = en_q;
      auto_d     = auto_q;
      ps_d       = ps_q;
      ts_d       = ts_q;
      trig_dly_d = {trig_dly_q[1:0], trig_edge & auto_q & en_q & (ts_q != acs_pkg::FREE_RUN_SRC)
                    & (state_q != acs_pkg::ST_CONV)};
      if (en_q && track) begin
         act_sel_d = tmp_sel_q;
      end
      // Register writes.
      if (wr && paddr == acs_pkg::ADDR_SELECT) begin
         tmp_sel_d.chan    = pwdata[acs_pkg::SEL_CHAN_LSB +: 4];
         tmp_sel_d.ref_sel = pwdata[acs_pkg::SEL_REF_LSB +: 2];
         left_d            = pwdata[acs_pkg::SEL_LEFT_BIT];
      end
      if (wr && paddr == acs_pkg::ADDR_CTRL_A) begin
         en_d   = pwdata[acs_pkg::CA_EN_BIT];
         auto_d = pwdata[acs_pkg::CA_AUTO_BIT];
         ps_d   = pwdata[acs_pkg::CA_PS_LSB +: 3];
         if (pwdata[acs_pkg::CA_FLAG_BIT]) begin
            flag_d = 1'b0;
         end
      end
      if (wr && paddr == acs_pkg::ADDR_CTRL_B) begin
         ts_d = pwdata[acs_pkg::CB_TS_LSB +: 3];
      end
      // Reading the low byte locks the result pair until the high byte is read.
      if (rd && paddr == acs_pkg::ADDR_RES_LOW) begin
         lock_d = 1'b1;
      end
      if (rd && paddr == acs_pkg::ADDR_RES_HIGH) begin
         lock_d = 1'b0;
      end
      // Conversion sequence.
      case (state_q)
         acs_pkg::ST_IDLE: begin
            if (wr && paddr == acs_pkg::ADDR_CTRL_A && pwdata[acs_pkg::CA_START_BIT]
                && pwdata[acs_pkg::CA_EN_BIT]) begin
               state_d = acs_pkg::ST_WAIT;
            end
         end
         acs_pkg::ST_WAIT: begin
            if (rise_tick) begin
               state_d = acs_pkg::ST_CONV;
               hcnt_d  = 6'h00;
               total_d = first_q ? acs_pkg::HALF_FIRST : acs_pkg::HALF_NORM;
               sh_d    = first_q ? acs_pkg::SH_FIRST : acs_pkg::SH_NORM;
            end
         end
         acs_pkg::ST_CONV: begin
            if (fall_tick || rise_tick) begin
               hcnt_d = hcnt_q + 6'h01;
               if (hcnt_q + 6'h01 == sh_q) begin
                  sample_d = 1'b1;
               end
               if (hcnt_q + 6'h01 == total_q) begin
                  done    = 1'b1;
                  first_d = 1'b0;
                  if (auto_q && ts_q == acs_pkg::FREE_RUN_SRC) begin
                     // Free running: next conversion begins at once, start bit stays set.
                     hcnt_d  = 6'h00;
                     total_d = acs_pkg::HALF_NORM;
                     sh_d    = acs_pkg::SH_NORM;
                  end else begin
                     state_d = acs_pkg::ST_IDLE;
                  end
               end
            end
         end
         default: begin
            state_d = acs_pkg::ST_IDLE;
         end
      endcase
      // Auto trigger, after three cycles of synchronisation.
      if (trig_go) begin
         state_d = acs_pkg::ST_CONV;
         hcnt_d  = 6'h00;
         total_d = first_q ? acs_pkg::HALF_FIRST : acs_pkg::HALF_AUTO;
         sh_d    = first_q ? acs_pkg::SH_FIRST : acs_pkg::SH_AUTO;
      end
      // Completion: the flag is set even when the locked result is discarded.
      if (done) begin
         flag_d = 1'b1;
         if (!lock_q) begin
            res_d = core_result;
         end
      end
      // Disabling aborts any conversion and rearms the long first conversion.
      if (!en_d) begin
         state_d    = acs_pkg::ST_IDLE;
         first_d    = 1'b1;
         trig_dly_d = 3'h0;
      end
      active_d = (state_d == acs_pkg::ST_CONV);
   end

   // Read data is prepared in the setup cycle, so every transfer has no wait state.
   always_comb begin
      prdata_d  = 32'h0000_0000;
      pslverr_d = 1'b0;
      pready_d  = psel & ~penable;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            acs_pkg::ADDR_SELECT: begin
               prdata_d[7:0] = {tmp_sel_q.ref_sel, left_q, 1'b0, tmp_sel_q.chan};
            end
            acs_pkg::ADDR_CTRL_A: begin
               prdata_d[7:0] = {en_q, state_q != acs_pkg::ST_IDLE, auto_q, flag_q, 1'b0, ps_q};
            end
            acs_pkg::ADDR_CTRL_B: begin
               prdata_d[7:0] = {5'h00, ts_q};
            end
            acs_pkg::ADDR_RES_LOW: begin
               prdata_d[7:0] = left_q ? {res_q[1:0], 6'h00} : res_q[7:0];
            end
            acs_pkg::ADDR_RES_HIGH: begin
               prdata_d[7:0] = left_q ? res_q[9:2] : {6'h00, res_q[9:8]};
            end
            default: begin
               pslverr_d = 1'b1;
            end
         endcase
      end else if (psel && !penable) begin
         pslverr_d = !(paddr inside {acs_pkg::ADDR_SELECT, acs_pkg::ADDR_CTRL_A,
                                     acs_pkg::ADDR_CTRL_B, acs_pkg::ADDR_RES_LOW,
                                     acs_pkg::ADDR_RES_HIGH});
      end
   end

   // All state registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q     <= acs_pkg::ST_IDLE;
         tmp_sel_q   <= '0;
         act_sel_q   <= '0;
         left_q      <= 1'b0;
         en_q        <= 1'b0;
         auto_q      <= 1'b0;
         flag_q      <= 1'b0;
         lock_q      <= 1'b0;
         first_q     <= 1'b1;
         trig_prev_q <= 1'b0;
         sample_q    <= 1'b0;
         adc_clk_q   <= 1'b0;
         active_q    <= 1'b0;
         ps_q        <= acs_pkg::PS_RST;
         ts_q        <= acs_pkg::TS_RST;
         trig_dly_q  <= 3'h0;
         hcnt_q      <= 6'h00;
         total_q     <= acs_pkg::HALF_NORM;
         sh_q        <= acs_pkg::SH_NORM;
         pcnt_q      <= 7'h00;
         res_q       <= 10'h000;
         prdata_q    <= 32'h0000_0000;
         pready_q    <= 1'b0;
         pslverr_q   <= 1'b0;
      end else begin
         state_q     <= state_d;
         tmp_sel_q   <= tmp_sel_d;
         act_sel_q   <= act_sel_d;
         left_q      <= left_d;
         en_q        <= en_d;
         auto_q      <= auto_d;
         flag_q      <= flag_d;
         lock_q      <= lock_d;
         first_q     <= first_d;
         trig_prev_q <= trig_src[ts_q];
         sample_q    <= sample_d;
         adc_clk_q   <= adc_clk_d;
         active_q    <= active_d;
         ps_q        <= ps_d;
         ts_q        <= ts_d;
         trig_dly_q  <= trig_dly_d;
         hcnt_q      <= hcnt_d;
         total_q     <= total_d;
         sh_q        <= sh_d;
         pcnt_q      <= pcnt_d;
         res_q       <= res_d;
         prdata_q    <= prdata_d;
         pready_q    <= pready_d;
         pslverr_q   <= pslverr_d;
      end
   end

   // Outputs straight from flip-flops.
   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
   assign adc_clk     = adc_clk_q;
   assign sample_hold = sample_q;
   assign conv_active = active_q;
   assign act_sel     = act_sel_q;

   // Checks on the sequencer.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   flag_on_done_a: assert property (done |=> flag_q)
      else $error("Completion did not set the flag.");
   locked_result_a: assert property (done && lock_q |=> res_q == $past(res_q))
      else $error("Locked result was overwritten.");
   trig_ignored_a: assert property (state_q == acs_pkg::ST_CONV |=> !trig_dly_q[0])
      else $error("Trigger edge accepted during a conversion.");
   first_length_a: assert property (state_q == acs_pkg::ST_WAIT && rise_tick && first_q
      |=> total_q == acs_pkg::HALF_FIRST && sh_q == acs_pkg::SH_FIRST && hcnt_q == 6'h00)
      else $error("First conversion has wrong length.");
   sample_point_a: assert property ($rose(sample_q) |-> hcnt_q == sh_q)
      else $error("Sample taken at wrong point.");
   prescaler_held_a: assert property (!en_q |=> pcnt_q == 7'h00)
      else $error("Prescaler ran while disabled.");
   sel_ignored_a: assert property (!en_q |=> $stable(act_sel_q))
      else $error("Selection applied while disabled.");
   start_reads_a: assert property (psel && !penable && !pwrite && paddr == acs_pkg::ADDR_CTRL_A
      && state_q == acs_pkg::ST_CONV |=> prdata_q[acs_pkg::CA_START_BIT])
      else $error("Start bit read low during conversion.");
   free_run_a: assert property (done && auto_q && ts_q == acs_pkg::FREE_RUN_SRC && en_d
      |=> state_q == acs_pkg::ST_CONV && hcnt_q == 6'h00)
      else $error("Free running did not restart.");
   sel_frozen_a: assert property (state_q == acs_pkg::ST_CONV
      && hcnt_q + acs_pkg::LAST_CYCLE < total_q |=> $stable(act_sel_q))
      else $error("Selection changed while locked.");

   first_done_c: cover property (done && total_q == acs_pkg::HALF_FIRST);
   discarded_c: cover property (done && lock_q);
   auto_done_c: cover property (done && total_q == acs_pkg::HALF_AUTO);
   free_run_c: cover property (done && auto_q && ts_q == acs_pkg::FREE_RUN_SRC);
endmodule

// >>> dv/acs_core_model.sv
// Behavioural model of the analog sampling core behind the sequencer.
`timescale 1ns/1ps
module acs_core_model (
   // Clock.
   input  wire logic                 pclk,
   // Sequencer side.
   input  wire logic                 sample_hold,
   input  wire acs_pkg::acs_sel_type act_sel,
   // Result back to the sequencer.
   output logic [9:0]                core_result
);
   // The sample encodes the applied selection, so a wrong channel shows up in the result.
   always @(posedge pclk) begin
      if (sample_hold === 1'b1) begin
         core_result <= {act_sel, 4'h5};
      end
   end
   // A real core holds its last sample until the next sample point.
   initial core_result = 10'h000;
endmodule

// >>> dv/acs_sequencer_bench.sv
// Self-checking bench of the conversion sequencer.
`timescale 1ns/1ps
module acs_sequencer_bench;
   localparam logic [31:0] EN    = 32'h1 << acs_pkg::CA_EN_BIT;
   localparam logic [31:0] START = 32'h1 << acs_pkg::CA_START_BIT;
   localparam logic [31:0] AUTO  = 32'h1 << acs_pkg::CA_AUTO_BIT;
   localparam logic [31:0] FLAG  = 32'h1 << acs_pkg::CA_FLAG_BIT;
   logic                 pclk;
   logic                 presetn;
   logic                 psel;
   logic                 penable;
   logic                 pwrite;
   logic [7:0]           paddr;
   logic [31:0]          pwdata;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic [7:0]           trig_src;
   logic [9:0]           core_result;
   logic                 adc_clk;
   logic                 sample_hold;
   logic                 conv_active;
   acs_pkg::acs_sel_type act_sel;
   int                   miscompares = 0;
   int                   comparisons = 0;
   int                   durs[$];
   int                   shs[$];
   int                   cnt = 0;
   int                   shp = 0;
   int                   d1, s1, d2, s2, d3, s3;
   logic [31:0]          q;
   logic                 err;

   acs_sequencer u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trig_src(trig_src), .core_result(core_result), .adc_clk(adc_clk),
      .sample_hold(sample_hold), .conv_active(conv_active), .act_sel(act_sel)
   );
   acs_core_model u_core (
      .pclk(pclk), .sample_hold(sample_hold), .act_sel(act_sel), .core_result(core_result)
   );

   // Free-running 50 MHz clock.
   always #10 pclk = ~pclk;

   // Records length and sample point of each run of conv_active, relative counts only.
   always @(posedge pclk) begin
      if (conv_active === 1'b1) begin
         cnt++;
         if (sample_hold === 1'b1) shp = cnt;
      end else if (cnt != 0) begin
         durs.push_back(cnt);
         shs.push_back(shp);
         cnt = 0;
      end
   end

   task automatic conclude();
      $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   // Holds the whole request until pready is sampled high, then releases it.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No wait limit here: a slave that never answers is left to the watchdog.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q, err);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, q, err);
      check($sformatf("read %h", a), e, q);
   endtask

   // Waits for the monitor to log one finished conversion.
   task automatic wait_conv(output int d, output int s);
      int n;
      n = 0;
      while (durs.size() == 0 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      d = 0;
      s = 0;
      check("conversion seen", 1, 32'(durs.size() > 0));
      if (durs.size() > 0) begin
         d = durs.pop_front();
         s = shs.pop_front();
      end
   endtask

   // Counts edges from one sample pulse to the next; free running never drops conv_active.
   task automatic sample_gap(output int g);
      int n;
      n = 0;
      g = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (sample_hold !== 1'b1 && n < 3000);
      do begin
         @(posedge pclk);
         g++;
      end while (sample_hold !== 1'b1 && g < 3000);
      check("sample pulses seen", 1, 32'(n < 3000 && g < 3000));
   endtask

   task automatic t_regs();
      rd(acs_pkg::ADDR_CTRL_A, 32'h0);
      apb(1'b0, 8'h14, 32'h0, q, err);
      check("unmapped error", 1, 32'(err));
      wr(acs_pkg::ADDR_SELECT, 32'hC3);
      repeat (4) @(posedge pclk);
      check("selection disabled", 32'h0, 32'(act_sel));
   endtask

   task automatic t_first();
      wr(acs_pkg::ADDR_CTRL_A, EN | START);
      rd(acs_pkg::ADDR_CTRL_A, EN | START);
      check("selection applied", 32'h33, 32'(act_sel));
      wait_conv(d1, s1);
      rd(acs_pkg::ADDR_CTRL_A, EN | FLAG);
      rd(acs_pkg::ADDR_RES_LOW, 32'h35);
      rd(acs_pkg::ADDR_RES_HIGH, 32'h03);
   endtask

   task automatic t_normal();
      wr(acs_pkg::ADDR_CTRL_A, EN | START | FLAG);
      // Reselect only after a full converter cycle has passed.
      repeat (6) @(posedge pclk);
      wr(acs_pkg::ADDR_SELECT, 32'h65);
      check("selection held", 32'h33, 32'(act_sel));
      wait_conv(d2, s2);
      check("first length", 24, 32'(d1 - d2));
      check("first sample", 24, 32'(s1 - s2));
      rd(acs_pkg::ADDR_RES_LOW, 32'h40);
      rd(acs_pkg::ADDR_RES_HIGH, 32'hCD);
      check("selection tracks", 32'h15, 32'(act_sel));
   endtask

   task automatic t_lock();
      // Prescaler code 2 divides by four, so every half period takes two clocks.
      wr(acs_pkg::ADDR_CTRL_A, EN | START | FLAG | 32'h2);
      rd(acs_pkg::ADDR_RES_LOW, 32'h40);
      wait_conv(d3, s3);
      check("divided length", 32'(2 * d2), 32'(d3));
      rd(acs_pkg::ADDR_CTRL_A, EN | FLAG | 32'h2);
      rd(acs_pkg::ADDR_RES_HIGH, 32'hCD);
      rd(acs_pkg::ADDR_RES_LOW, 32'h40);
   endtask

   task automatic t_auto();
      wr(acs_pkg::ADDR_CTRL_B, 32'h1);
      // Reselect while auto-trigger is still off, the safe moment.
      wr(acs_pkg::ADDR_SELECT, 32'h62);
      wr(acs_pkg::ADDR_CTRL_A, EN | AUTO | FLAG);
      @(posedge pclk) trig_src <= 8'h02;
      repeat (10) @(posedge pclk);
      trig_src <= 8'h00;
      @(posedge pclk) trig_src <= 8'h02;
      wait_conv(d3, s3);
      check("auto length", 32'(d2 + 1), 32'(d3));
      check("auto sample", 32'(s2 + 1), 32'(s3));
      check("selection auto", 32'h12, 32'(act_sel));
      repeat (80) @(posedge pclk);
      check("extra conversions", 0, 32'(durs.size()));
      rd(acs_pkg::ADDR_CTRL_A, EN | AUTO | FLAG);
      wr(acs_pkg::ADDR_CTRL_A, EN | AUTO | START | FLAG);
      wait_conv(d3, s3);
      check("start under auto", 32'(d2), 32'(d3));
      trig_src <= 8'h00;
   endtask

   task automatic t_free();
      int bad;
      bad = 0;
      wr(acs_pkg::ADDR_CTRL_B, 32'h0);
      wr(acs_pkg::ADDR_CTRL_A, EN | AUTO | START);
      for (int i = 0; i < 3; i++) begin
         sample_gap(d3);
         check("free length", 32'(d2), 32'(d3));
         rd(acs_pkg::ADDR_CTRL_A, EN | AUTO | START | FLAG);
      end
      wr(acs_pkg::ADDR_CTRL_A, 32'h0);
      repeat (3) @(posedge pclk);
      durs.delete();
      shs.delete();
      repeat (20) begin
         @(posedge pclk);
         if (adc_clk !== 1'b0) bad++;
      end
      check("converter clock idle", 0, 32'(bad));
      check("stopped", 0, 32'(durs.size()));
   endtask

   // Cuts a hang short well past the expected run length.
   initial begin
      #400000;
      miscompares++;
      conclude();
   end

   // Reset, then the scenarios in order.
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      trig_src = 8'h00;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_first();
      t_normal();
      t_lock();
      t_auto();
      t_free();
      conclude();
   end
endmodule
